//--- hw/adc_powerfail_control.sv
// converter control: registers, wait-cycle insertion, conversion timing, power-fail compare
`timescale 1ns/1ps
`default_nettype none
module adc_powerfail_control
    import adc_pf_pkg::*;
#(
    parameter int RESULT_W = RES_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest,
    // analog front end
    input wire logic [RESULT_W-1:0] sample_value,
    output logic [CHAN_W-1:0] sample_channel,
    output logic comparator_on,
    // system
    input wire logic standby,
    output logic conversion_done_irq,
    output logic powerfail_irq
);
    initial begin
        if (RESULT_W < 8 || RESULT_W > 16) begin
            $error("RESULT_W out of range");
        end
        if (SETTLE_CYC >= (1 << CNT_W)) begin
            $error("settle count does not fit the counter");
        end
    end

    typedef struct packed {
        logic [7:0] converter_mode_reg;
        logic [7:0] channel_select_reg;
        logic [RESULT_W-1:0] conversion_result_reg;
        logic [7:0] powerfail_mode_reg;
        logic [7:0] powerfail_threshold_reg;
        conv_e conv_state;
        logic [CNT_W-1:0] conv_cnt;
        logic [CNT_W-1:0] settle_cnt;
        logic waited;
        logic [DATA_W-1:0] rdata;
        logic done_irq;
        logic pf_irq;
        logic pending;
        logic [RESULT_W-1:0] pending_val;
    } state_s;

    state_s cur;
    state_s next_cur;

    logic needs_wait;
    logic mode_wr;
    logic chan_wr;
    logic res_rd;
    logic conv_end;
    logic [CNT_W-1:0] tsel_cyc;
    logic [7:0] sample8;

    // wait-cycle registers: channel write, result read, power-fail writes
    always_comb begin
        needs_wait = 1'b0;
        if (write && (address == OFS_CHAN || address == OFS_PFMODE || address == OFS_PFTHR)) begin
            needs_wait = 1'b1;
        end
        if (read && address == OFS_RESULT) begin
            needs_wait = 1'b1;
        end
    end

    assign waitrequest = needs_wait && !cur.waited;
    assign mode_wr = write && !waitrequest && address == OFS_MODE;
    assign chan_wr = write && !waitrequest && address == OFS_CHAN;
    assign res_rd = read && !waitrequest && address == OFS_RESULT;
    assign tsel_cyc = CNT_W'(TSEL_BASE_CYC) << cur.converter_mode_reg[MODE_TSEL_HI:MODE_TSEL_LO];
    assign conv_end = cur.conv_state != conv_idle && cur.conv_cnt == '0;
    assign sample8 = sample_value[RESULT_W-1 -: 8];

    always_comb begin
        next_cur = cur;
        next_cur.done_irq = 1'b0;
        next_cur.pf_irq = 1'b0;
        next_cur.waited = needs_wait && !cur.waited;
        // settling counter after comparator enable
        if (!cur.converter_mode_reg[MODE_CMP_BIT]) begin
            next_cur.settle_cnt = '0;
        end else if (cur.settle_cnt != CNT_W'(SETTLE_CYC)) begin
            next_cur.settle_cnt = cur.settle_cnt + 1'b1;
        end
        // deferred result store after a same-cycle read
        if (cur.pending) begin
            next_cur.conversion_result_reg = cur.pending_val;
            next_cur.pending = 1'b0;
        end
        // conversion engine
        case (cur.conv_state)
            conv_idle: begin
                if (cur.converter_mode_reg[MODE_RUN_BIT] && !standby) begin
                    next_cur.conv_state = conv_first;
                    next_cur.conv_cnt = tsel_cyc + CNT_W'(FIRST_EXTRA_CYC);
                end
            end
            conv_first, conv_run: begin
                if (!cur.converter_mode_reg[MODE_RUN_BIT] || standby) begin
                    next_cur.conv_state = conv_idle;
                end else if (conv_end) begin
                    next_cur.conv_state = conv_run;
                    next_cur.conv_cnt = tsel_cyc - 1'b1;
                    if (!(mode_wr || chan_wr)) begin
                        if (res_rd) begin
                            next_cur.pending = 1'b1;
                            next_cur.pending_val = sample_value;
                        end else begin
                            next_cur.conversion_result_reg = sample_value;
                        end
                        if (cur.powerfail_mode_reg[PF_EN_BIT]) begin
                            if ((sample8 < cur.powerfail_threshold_reg) == cur.powerfail_mode_reg[PF_BELOW_BIT]) begin
                                next_cur.powerfail_mode_reg[PF_FLAG_BIT] = 1'b1;
                                next_cur.pf_irq = 1'b1;
                            end else begin
                                next_cur.powerfail_mode_reg[PF_FLAG_BIT] = 1'b0;
                            end
                        end else begin
                            next_cur.done_irq = 1'b1;
                        end
                    end
                end else begin
                    next_cur.conv_cnt = cur.conv_cnt - 1'b1;
                end
            end
            default: next_cur.conv_state = conv_idle;
        endcase
        // register writes; mode/channel write restarts timing and spoils the result
        if (write && !waitrequest) begin
            case (address)
                OFS_MODE: begin
                    next_cur.converter_mode_reg = writedata[7:0];
                    next_cur.conv_state = conv_idle;
                    next_cur.pending = 1'b0;
                end
                OFS_CHAN: begin
                    next_cur.channel_select_reg = writedata[7:0] & ~CHAN_RESERVED_MASK;
                    next_cur.conv_state = conv_idle;
                    next_cur.pending = 1'b0;
                end
                OFS_PFMODE: next_cur.powerfail_mode_reg = {writedata[7:1], cur.powerfail_mode_reg[PF_FLAG_BIT]};
                OFS_PFTHR: next_cur.powerfail_threshold_reg = writedata[7:0];
                default: ;
            endcase
        end
        // status word: busy, steady run, settled; registered so a no-wait read sees the live state
        next_cur.rdata = '0;
        if (next_cur.conv_state != conv_idle) begin
            next_cur.rdata[0] = 1'b1;
        end
        if (next_cur.conv_state == conv_run) begin
            next_cur.rdata[1] = 1'b1;
        end
        if (next_cur.settle_cnt == CNT_W'(SETTLE_CYC)) begin
            next_cur.rdata[2] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // read data is combinational from the decode held one cycle: answer on the edge where waitrequest is low
    always_comb begin
        readdata = '0;
        if (read) begin
            case (address)
                OFS_MODE: readdata[7:0] = cur.converter_mode_reg;
                OFS_CHAN: readdata[7:0] = cur.channel_select_reg;
                OFS_RESULT: readdata[RESULT_W-1:0] = cur.conversion_result_reg;
                OFS_PFMODE: readdata[7:0] = cur.powerfail_mode_reg;
                OFS_PFTHR: readdata[7:0] = cur.powerfail_threshold_reg;
                OFS_STATUS: readdata[2:0] = cur.rdata[2:0];
                default: readdata = '0;
            endcase
        end
    end

    assign sample_channel = cur.channel_select_reg[CHAN_W-1:0];
    assign comparator_on = cur.converter_mode_reg[MODE_CMP_BIT] && !standby;
    assign conversion_done_irq = cur.done_irq;
    assign powerfail_irq = cur.pf_irq;
endmodule
`default_nettype wire

//--- pkg/adc_pf_pkg.sv
// package: register map, fields and timing for the converter control block
package adc_pf_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int RES_W = 10;
    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CHAN = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_PFMODE = 4'hc;
    // threshold register sits at a second page bit (address 0x10 folded to 4 bits is not possible)
    localparam logic [ADDR_W-1:0] OFS_PFTHR = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h6;
    // mode register fields
    localparam int MODE_RUN_BIT = 7;
    localparam int MODE_TSEL_HI = 5;
    localparam int MODE_TSEL_LO = 3;
    localparam int MODE_CMP_BIT = 0;
    localparam int CHAN_W = 3;
    // power-fail mode fields
    localparam int PF_EN_BIT = 7;
    localparam int PF_BELOW_BIT = 6;
    localparam int PF_FLAG_BIT = 0;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_US = 14;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int TSEL_BASE_CYC = 64;
    localparam int FIRST_EXTRA_CYC = 32;
    localparam int CNT_W = 16;
    localparam logic [7:0] CHAN_RESERVED_MASK = 8'hf8;

    typedef enum logic [1:0] {
        conv_idle,
        conv_first,
        conv_run
    } conv_e;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [DATA_W-1:0] writedata;
    } bus_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic waitrequest;
    } bus_rsp_s;
endpackage

//--- sim/adc_powerfail_control_asserts.sv
// checker: bus wait cycles, conversion pulses and standby
`timescale 1ns/1ps
`default_nettype none
module adc_powerfail_control_asserts
    import adc_pf_pkg::*;
(
    // clock, reset and bus
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // status
    input wire logic standby,
    input wire logic comparator_on,
    input wire logic conversion_done_irq
);
    logic pend;
    logic first;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
        end else begin
            pend <= (read | write) & waitrequest;
        end
    end
    assign first = (read | write) & ~pend;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    a_chan_wait: assert property (first && write && address == OFS_CHAN |-> one_wait)
        else $error("channel write wait wrong");
    a_result_wait: assert property (first && read && address == OFS_RESULT |-> one_wait)
        else $error("result read wait wrong");
    a_pfmode_wait: assert property (first && write && address == OFS_PFMODE |-> one_wait)
        else $error("pf mode write wait wrong");
    a_pfthr_wait: assert property (first && write && address == OFS_PFTHR |-> one_wait)
        else $error("pf threshold write wait wrong");
    a_standby_quiet: assert property (standby && $past(standby) && $past(standby, 2) |-> !conversion_done_irq)
        else $error("irq during standby");
    a_standby_cmp: assert property (standby |-> !comparator_on)
        else $error("comparator on in standby");
    a_irq_gap: assert property (conversion_done_irq |=> !conversion_done_irq [*8])
        else $error("done pulses too close");
    a_write_abort: assert property (write && !waitrequest && (address == OFS_MODE || address == OFS_CHAN)
        |=> !conversion_done_irq)
        else $error("irq after register write");
endmodule
bind adc_powerfail_control adc_powerfail_control_asserts u_adc_powerfail_control_asserts (.sys_clk(sys_clk),
    .rst(rst), .address(address), .read(read), .write(write), .waitrequest(waitrequest), .standby(standby),
    .comparator_on(comparator_on), .conversion_done_irq(conversion_done_irq));
`default_nettype wire

//--- sim/adc_powerfail_control_tb_top.sv
// testbench: bus accesses, conversion timing, abort and standby
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %0h want %0h", $time, (a), (e)); end end
module adc_powerfail_control_tb_top
    import adc_pf_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
    logic [RES_W-1:0] sample_value;
    logic [CHAN_W-1:0] sample_channel;
    logic comparator_on;
    logic standby = 1'b0;
    logic conversion_done_irq;
    logic powerfail_irq;
    logic [9:0] level = '0;
    logic [31:0] seed = 32'h0e14;
    logic [DATA_W-1:0] rd;
    int errors = 0;
    int total_checks = 0;
    int n;
    int t1;
    int t2;
    logic [2:0] ch;
    always #5 sys_clk = ~sys_clk;
    adc_powerfail_control u_adc_powerfail_control (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .sample_value(sample_value), .sample_channel(sample_channel), .comparator_on(comparator_on),
        .standby(standby), .conversion_done_irq(conversion_done_irq), .powerfail_irq(powerfail_irq));
    adc_sample_src u_adc_sample_src (.chan(sample_channel), .level(level), .sample_value(sample_value));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one bus access; returns the number of wait cycles seen
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d, output int waits);
        waits = 0;
        @(posedge sys_clk);
        address <= a;
        read <= !we;
        write <= we;
        writedata <= {24'h000000, d};
        for (int k = 0; k <= 20; k++) begin
            @(posedge sys_clk);
            if (waitrequest === 1'b0) break;
            waits++;
        end
        if (waitrequest !== 1'b0) begin errors++; results(); end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // cycles until the next done or power-fail pulse, bounded
    task automatic wait_irq(input logic pf, output int c);
        c = 0;
        do begin
            @(negedge sys_clk);
            c++;
            if (c > 20000) begin errors++; results(); end
        end while ((pf ? powerfail_irq : conversion_done_irq) !== 1'b1);
    endtask
    task automatic watch(input logic pf, input int len, output int hits);
        hits = 0;
        repeat (len) begin
            @(negedge sys_clk);
            if ((pf ? powerfail_irq : conversion_done_irq) === 1'b1) hits++;
        end
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b0, OFS_RESULT, 8'h00, n); `CHK(n, 1)
        `CHK(rd[RES_W-1:0], 10'h000)
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            ch = seed[2:0];
            level <= seed[13:4];
            bus(1'b1, OFS_MODE, 8'h00, n);
            bus(1'b1, OFS_CHAN, {5'h00, ch}, n); `CHK(n, 1)
            @(negedge sys_clk);
            `CHK(sample_channel, ch)
            bus(1'b1, OFS_PFMODE, 8'h00, n); `CHK(n, 1)
            bus(1'b1, OFS_PFTHR, seed[23:16], n); `CHK(n, 1)
            bus(1'b1, OFS_MODE, 8'h01, n);
            @(negedge sys_clk);
            `CHK(comparator_on, 1'b1)
            repeat (SETTLE_CYC) @(posedge sys_clk);
            bus(1'b0, OFS_STATUS, 8'h00, n); `CHK(rd[2:0], 3'h4)
            bus(1'b1, OFS_MODE, 8'h81 | (i[7:0] << 3), n);
            wait_irq(1'b0, t1);
            wait_irq(1'b0, t2); `CHK(t2, 64 << i)
            `CHK(t1 > t2, 1'b1)
            bus(1'b0, OFS_STATUS, 8'h00, n); `CHK(rd[2:0], 3'h7)
            bus(1'b0, OFS_RESULT, 8'h00, n); `CHK(rd[RES_W-1:0], seed[13:4] + {7'h00, ch})
        end
        // mode write taken in the very cycle the running conversion ends
        wait_irq(1'b0, t1);
        repeat (254) @(posedge sys_clk);
        bus(1'b1, OFS_MODE, 8'h91, n);
        watch(1'b0, 30, n); `CHK(n, 0)
        @(posedge sys_clk);
        standby <= 1'b1;
        watch(1'b0, 600, n); `CHK(n, 0)
        `CHK(comparator_on, 1'b0)
        @(posedge sys_clk);
        standby <= 1'b0;
        // start without the enable step: first result is thrown away
        bus(1'b1, OFS_MODE, 8'h00, n);
        level <= 10'h155;
        bus(1'b1, OFS_MODE, 8'h80, n);
        wait_irq(1'b0, t1);
        wait_irq(1'b0, t2); `CHK(t2, 64)
        bus(1'b0, OFS_RESULT, 8'h00, n); `CHK(rd[RES_W-1:0], 10'h155 + {7'h00, ch})
        // power-fail sequence: enable, threshold and compare mode, settle, start
        bus(1'b1, OFS_MODE, 8'h00, n);
        level <= 10'h000;
        bus(1'b1, OFS_MODE, 8'h01, n);
        bus(1'b1, OFS_PFTHR, 8'h80, n);
        bus(1'b1, OFS_PFMODE, 8'hc0, n);
        repeat (SETTLE_CYC) @(posedge sys_clk);
        bus(1'b1, OFS_MODE, 8'h81, n);
        wait_irq(1'b1, t1);
        wait_irq(1'b1, t2); `CHK(t2, 64)
        bus(1'b0, OFS_PFMODE, 8'h00, n); `CHK(rd[7:0], 8'hc1)
        watch(1'b0, 100, n); `CHK(n, 0)
        bus(1'b1, OFS_PFTHR, 8'h00, n); `CHK(n, 1)
        watch(1'b1, 200, n); `CHK(n, 0)
        bus(1'b0, OFS_PFMODE, 8'h00, n); `CHK(rd[7:0], 8'hc0)
        results();
    end
endmodule
`default_nettype wire

//--- sim/adc_sample_src.sv
// analog front end model: one shared sample level plus the channel number
`timescale 1ns/1ps
`default_nettype none
module adc_sample_src (
    // channel and level
    input wire logic [2:0] chan,
    input wire logic [9:0] level,
    // sample to the converter
    output logic [9:0] sample_value
);
    assign sample_value = level + {7'h00, chan};
endmodule
`default_nettype wire
